// File: port_pkg.sv
// package: register map, widths and reset values of the memory-mapped output port
package port_pkg;
   localparam int DATA_W = 8;
   localparam int REG_W = 32;
   localparam int ADDR_W = 3;
   localparam logic [ADDR_W-1:0] OFS_PORT_DATA = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_PIN_DIRECTION = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_MASK = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_EDGE_DETECT_FLAGS = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_BIT_SET = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_BIT_CLEAR = 3'h5;
   localparam logic [DATA_W-1:0] RST_OUT = 8'h00;
   localparam logic [DATA_W-1:0] RST_DIR = 8'h00;
   localparam logic [DATA_W-1:0] RST_MASK = 8'h00;
   localparam int HEARTBEAT_BIT = 0;
   localparam int HEARTBEAT_HALF = 20000000;
   localparam int HB_CNT_W = 25;
endpackage : port_pkg

// File: pin_sync.sv
// two-stage synchroniser for the input pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_nxt;
   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_out <= sync_nxt;
      end
   end
endmodule : pin_sync

// File: output_port.sv
// memory-mapped parallel output port with direction, mask, edge capture and set/clear
//
// Contract
// [R1] data read returns synchronised input pin levels
// [R2] data write loads new output levels
// [R3] direction bit: 0 input, 1 output
// [R4] mask bit 1 enables that pin's interrupt
// [R5] edge flags record detected pin edges
// [R6] set register raises selected output bits
// [R7] clear register lowers selected output bits
// [R8] registers 32 bits, full-word access only
// [R9] eight pin bits, upper bits inert
// [R10] host maps port at base, 16 bytes; the registers here reach offset 20, a 24-byte span
// [R11] outputs active high toward indicators
// [R12] lowest indicator driven by heartbeat instead
// [R13] set/clear touch only bits written one
`timescale 1ns/1ps
module output_port
   import port_pkg::*;
#(
   parameter int WIDTH = port_pkg::DATA_W,
   parameter int HB_HALF = port_pkg::HEARTBEAT_HALF
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [port_pkg::ADDR_W-1:0] address,
   input wire logic write_en,
   input wire logic read_en,
   input wire logic [port_pkg::REG_W-1:0] write_data,
   output logic [port_pkg::REG_W-1:0] read_data,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] indicator,
   output logic irq
);
   import port_pkg::*;

   // ****************************************
   // input synchronisation
   // ****************************************
   logic [WIDTH-1:0] pin_s;
   pin_sync #(.W(WIDTH)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in(pin_in),
      .sync_out(pin_s)
   );

   // ****************************************
   // register state
   // ****************************************
   logic [WIDTH-1:0] out_r, out_nxt;
   logic [WIDTH-1:0] dir_r, dir_nxt;
   logic [WIDTH-1:0] mask_r, mask_nxt;
   logic [WIDTH-1:0] edge_r, edge_nxt;
   logic [WIDTH-1:0] prev_r, prev_nxt;
   logic [REG_W-1:0] rd_r, rd_nxt;
   logic irq_r, irq_nxt;
   logic [HB_CNT_W-1:0] hb_cnt_r, hb_cnt_nxt;
   logic hb_r, hb_nxt;
   logic [WIDTH-1:0] wr_bits;
   logic [WIDTH-1:0] edges;
   logic [2:0] arm_r, arm_nxt;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // upper data bits are dropped: only the pin slice carries meaning [R9]
   assign wr_bits = write_data[WIDTH-1:0];
   // edges count only once synchroniser and previous level hold real pins;
   // otherwise a pin idling high reports a false edge after every reset
   assign edges = (pin_s ^ prev_r) & {WIDTH{arm_r[2]}};

   always_comb begin
      out_nxt = out_r;
      dir_nxt = dir_r;
      mask_nxt = mask_r;
      prev_nxt = pin_s;
      arm_nxt = {arm_r[1:0], 1'b1};
      // a new edge wins over a clear in the same cycle
      edge_nxt = edge_r;
      rd_nxt = '0;
      // every access is a full word; no byte lanes exist [R8]
      if (write_en) begin
         if (hit(address, OFS_PORT_DATA)) out_nxt = wr_bits; // [R2] [R11]
         if (hit(address, OFS_PIN_DIRECTION)) dir_nxt = wr_bits; // [R3]
         if (hit(address, OFS_IRQ_ENABLE_MASK)) mask_nxt = wr_bits; // [R4]
         if (hit(address, OFS_EDGE_DETECT_FLAGS)) edge_nxt = edge_r & ~wr_bits; // [R5]
         if (hit(address, OFS_OUTPUT_BIT_SET)) out_nxt = out_r | wr_bits; // [R6] [R13]
         if (hit(address, OFS_OUTPUT_BIT_CLEAR)) out_nxt = out_r & ~wr_bits; // [R7] [R13]
      end
      edge_nxt = edge_nxt | (edges & ~dir_r); // [R5]
      if (read_en) begin
         case (address)
            OFS_PORT_DATA: rd_nxt[WIDTH-1:0] = pin_s; // [R1]
            OFS_PIN_DIRECTION: rd_nxt[WIDTH-1:0] = dir_r;
            OFS_IRQ_ENABLE_MASK: rd_nxt[WIDTH-1:0] = mask_r;
            OFS_EDGE_DETECT_FLAGS: rd_nxt[WIDTH-1:0] = edge_r;
            default: rd_nxt = '0;
         endcase
      end
      irq_nxt = |(edge_r & mask_r); // [R4]
   end

   // ****************************************
   // heartbeat for the lowest indicator
   // ****************************************
   always_comb begin
      hb_cnt_nxt = hb_cnt_r + 1'b1;
      hb_nxt = hb_r;
      if (hb_cnt_r == HB_CNT_W'(HB_HALF - 1)) begin
         hb_cnt_nxt = '0;
         hb_nxt = ~hb_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         out_r <= RST_OUT;
         dir_r <= RST_DIR;
         mask_r <= RST_MASK;
         edge_r <= '0;
         prev_r <= '0;
         arm_r <= '0;
         rd_r <= '0;
         irq_r <= 1'b0;
         hb_cnt_r <= '0;
         hb_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
         dir_r <= dir_nxt;
         mask_r <= mask_nxt;
         edge_r <= edge_nxt;
         prev_r <= prev_nxt;
         arm_r <= arm_nxt;
         rd_r <= rd_nxt;
         irq_r <= irq_nxt;
         hb_cnt_r <= hb_cnt_nxt;
         hb_r <= hb_nxt;
      end
   end

   // ****************************************
   // output pins, registered
   // ****************************************
   logic [WIDTH-1:0] pin_out_r, pin_oe_r, ind_r;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pin_out_r <= '0;
         pin_oe_r <= '0;
         ind_r <= '0;
      end else begin
         pin_out_r <= out_r;
         pin_oe_r <= dir_r; // [R3]
         ind_r <= out_r; // [R11]
         // heartbeat owns the lowest indicator; a limitation software must live with [R12]
         ind_r[HEARTBEAT_BIT] <= hb_r; // [R12]
      end
   end
   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;
   assign indicator = ind_r;
   assign read_data = rd_r;
   assign irq = irq_r;

   // ****************************************
   // assertions
   // ****************************************
   property p_data_write;
      @(posedge sys_clk) disable iff (!rst_n)
      write_en && address == OFS_PORT_DATA |=> out_r == $past(write_data[WIDTH-1:0]);
   endproperty
   a_data_write: assert property (p_data_write) else $error("data write not loaded"); // [R2]
   property p_data_read;
      @(posedge sys_clk) disable iff (!rst_n)
      read_en && address == OFS_PORT_DATA |=> read_data == REG_W'($past(pin_s));
   endproperty
   a_data_read: assert property (p_data_read) else $error("data read wrong"); // [R1]
   property p_dir;
      @(posedge sys_clk) disable iff (!rst_n)
      write_en && address == OFS_PIN_DIRECTION |=> ##1 pin_oe == $past(write_data[WIDTH-1:0], 2);
   endproperty
   a_dir: assert property (p_dir) else $error("direction not applied"); // [R3]
   property p_irq;
      @(posedge sys_clk) disable iff (!rst_n)
      (|(edge_r & mask_r)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("masked irq missing"); // [R4]
   property p_edge;
      @(posedge sys_clk) disable iff (!rst_n)
      (|(edges & ~dir_r)) |=> (|edge_r);
   endproperty
   a_edge: assert property (p_edge) else $error("edge not captured"); // [R5]
   property p_set;
      @(posedge sys_clk) disable iff (!rst_n)
      write_en && address == OFS_OUTPUT_BIT_SET |=> out_r == ($past(out_r) | $past(write_data[WIDTH-1:0]));
   endproperty
   a_set: assert property (p_set) else $error("set wrong"); // [R6] [R13]
   property p_clr;
      @(posedge sys_clk) disable iff (!rst_n)
      write_en && address == OFS_OUTPUT_BIT_CLEAR |=> out_r == ($past(out_r) & ~$past(write_data[WIDTH-1:0]));
   endproperty
   a_clr: assert property (p_clr) else $error("clear wrong"); // [R7] [R13]
   property p_ind;
      @(posedge sys_clk) disable iff (!rst_n)
      ##1 indicator[WIDTH-1:1] == $past(out_r[WIDTH-1:1]) && indicator[HEARTBEAT_BIT] == $past(hb_r);
   endproperty
   a_ind: assert property (p_ind) else $error("indicator mismatch"); // [R11] [R12]
   property p_unmapped;
      @(posedge sys_clk) disable iff (!rst_n)
      read_en && address > OFS_EDGE_DETECT_FLAGS |=> read_data == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("write-only read nonzero"); // [R9]
   c_write: cover property (@(posedge sys_clk) write_en && address == OFS_PORT_DATA);
   c_set: cover property (@(posedge sys_clk) write_en && address == OFS_OUTPUT_BIT_SET);
   c_irq: cover property (@(posedge sys_clk) irq);
endmodule : output_port

// File: host_model.sv
// host model: full-word register accesses through the bridge window
`timescale 1ns/1ps
module host_model (
   input wire logic sys_clk,
   output logic [port_pkg::ADDR_W-1:0] address,
   output logic write_en,
   output logic read_en,
   output logic [port_pkg::REG_W-1:0] write_data,
   input wire logic [port_pkg::REG_W-1:0] read_data
);
   initial begin
      address = 3'h0;
      write_en = 1'b0;
      read_en = 1'b0;
      write_data = 32'h0;
   end
   // byte offset inside the window; base decode happens upstream
   task automatic wr(input int ofs, input logic [31:0] d);
      address = 3'(ofs >> 2);
      write_data = d;
      write_en = 1'b1;
      @(posedge sys_clk);
      #1;
      write_en = 1'b0;
      // idle cycle so a strobe never drops and rises in one step
      @(posedge sys_clk);
      #1;
   endtask : wr
   task automatic rd(input int ofs, output logic [31:0] d);
      address = 3'(ofs >> 2);
      read_en = 1'b1;
      @(posedge sys_clk);
      #1;
      read_en = 1'b0;
      d = read_data;
      @(posedge sys_clk);
      #1;
   endtask : rd
endmodule : host_model

// File: memory_mapped_output_port_tb.sv
// self-checking bench for the memory-mapped output port
`timescale 1ns/1ps
module memory_mapped_output_port_tb;
   import port_pkg::*;
   logic sys_clk;
   logic rst_n;
   logic [ADDR_W-1:0] address;
   logic write_en;
   logic read_en;
   logic [REG_W-1:0] write_data;
   logic [REG_W-1:0] read_data;
   logic [DATA_W-1:0] pin_in;
   logic [DATA_W-1:0] pin_out;
   logic [DATA_W-1:0] pin_oe;
   logic [DATA_W-1:0] indicator;
   logic irq;
   logic [REG_W-1:0] rv;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   output_port #(.WIDTH(DATA_W), .HB_HALF(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .address(address),
      .write_en(write_en), .read_en(read_en), .write_data(write_data), .read_data(read_data),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .indicator(indicator), .irq(irq));
   host_model host (.sys_clk(sys_clk), .address(address), .write_en(write_en), .read_en(read_en),
      .write_data(write_data), .read_data(read_data));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   // hang guard: the whole sequence needs under a hundred cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic t_data;
      host.wr(0, 32'h0000007f);
      tick(1);
      chk("pin_out", 32'h7f, 32'(pin_out));
      chk("indicator", 32'h3f, 32'(indicator[7:1]));
      host.wr(0, 32'h000000ff);
      tick(1);
      chk("indicator", 32'h7f, 32'(indicator[7:1]));
      host.wr(0, 32'h00000000);
      tick(1);
      chk("indicator", 32'h0, 32'(indicator[7:1]));
      $display("test data done");
   endtask : t_data
   task automatic t_setclr;
      host.wr(0, 32'h0000000f);
      host.wr(16, 32'h000000a0);
      tick(1);
      chk("pin_out", 32'haf, 32'(pin_out));
      host.wr(20, 32'h00000083);
      tick(1);
      chk("pin_out", 32'h2c, 32'(pin_out));
      $display("test set clear done");
   endtask : t_setclr
   task automatic t_dir;
      chk("pin_oe", 32'h0, 32'(pin_oe));
      host.wr(4, 32'hffffff5a);
      tick(1);
      host.rd(4, rv);
      chk("direction", 32'h5a, rv);
      chk("pin_oe", 32'h5a, 32'(pin_oe));
      host.rd(16, rv);
      chk("set read", 32'h0, rv);
      host.wr(4, 32'h0);
      $display("test direction done");
   endtask : t_dir
   task automatic t_pins;
      pin_in = 8'h3c;
      tick(3);
      host.rd(0, rv);
      chk("pins", 32'h3c, rv);
      $display("test pins done");
   endtask : t_pins
   task automatic t_edge;
      host.wr(8, 32'h01);
      host.rd(8, rv);
      chk("mask", 32'h1, rv);
      host.wr(12, 32'hff);
      tick(1);
      chk("irq", 32'h0, 32'(irq));
      pin_in = 8'h3f;
      tick(4);
      host.rd(12, rv);
      chk("edge flags", 32'h03, rv);
      chk("irq", 32'h1, 32'(irq));
      // bit 1 stays flagged but masked, so the request must drop
      host.wr(12, 32'h01);
      tick(2);
      chk("irq", 32'h0, 32'(irq));
      host.rd(12, rv);
      chk("edge flags", 32'h02, rv);
      $display("test edge done");
   endtask : t_edge
   // mid-run reset with pins 5:0 held high: no false edge may be flagged afterwards
   task automatic t_reset;
      host.wr(0, 32'h000000ff);
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      chk("pin_out", 32'h0, 32'(pin_out));
      chk("indicator", 32'h0, 32'(indicator));
      chk("irq", 32'h0, 32'(irq));
      tick(4);
      host.rd(12, rv);
      chk("edge flags", 32'h0, rv);
      host.rd(0, rv);
      chk("pins", 32'h3f, rv);
      $display("test reset done");
   endtask : t_reset
   // heartbeat half period is 4 cycles in this bench, so 16 cycles hold 4 flips
   task automatic t_beat;
      logic last;
      int flips;
      host.wr(0, 32'h00000001);
      last = indicator[HEARTBEAT_BIT];
      flips = 0;
      repeat (16) begin
         tick(1);
         if (indicator[HEARTBEAT_BIT] !== last) flips++;
         last = indicator[HEARTBEAT_BIT];
      end
      chk("heartbeat flips", 32'h4, 32'(flips));
      $display("test heartbeat done");
   endtask : t_beat
   initial begin
      rst_n = 1'b0;
      pin_in = 8'h00;
      repeat (16) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      t_data();
      t_setclr();
      t_dir();
      t_pins();
      t_edge();
      t_reset();
      t_beat();
      wrap_up();
   end
endmodule : memory_mapped_output_port_tb
